// ===== pkg/cgen_pkg.sv
package cgen_pkg;

  // Register file addresses on the special function register port
  localparam logic [7:0] SFR_TRIM  = 8'h96;
  localparam logic [7:0] SFR_CDIV  = 8'h95;
  localparam logic [7:0] SFR_AUXCT = 8'hA2;

  // Field positions and widths
  localparam int TRIM_SEL_BIT = 7;
  localparam int TRIM_W       = 6;
  localparam int AUX_LP_BIT   = 7;
  localparam int UCFG_DBL_BIT = 3;
  localparam int UCFG_SRC_LSB = 0;

  // Reset values
  localparam logic [7:0] CDIV_RST  = 8'h00;
  localparam logic [7:0] AUXCT_RST = 8'h00;

  // Clock source codes held in the user configuration byte
  localparam logic [1:0] UCFG_SRC_EXT = 2'h0;
  localparam logic [1:0] UCFG_SRC_WDT = 2'h2;
  localparam logic [1:0] UCFG_SRC_RC  = 2'h3;

  // Rates
  localparam longint MCLK_HZ    = 40_000_000;
  localparam longint WDT_OSC_HZ = 400_000;
  localparam longint RC_NOM_HZ  = 7_373_000;
  localparam int     WDT_DIV    = int'(MCLK_HZ / WDT_OSC_HZ);

  // RC model: phase accumulator, trim moves the step around mid code
  localparam int          ACC_W        = 20;
  localparam logic [ACC_W-1:0] RC_STEP =
    ACC_W'((RC_NOM_HZ * (64'h1 << ACC_W)) / MCLK_HZ);
  localparam logic [ACC_W-1:0] RC_TRIM_LSB = 20'h000C8;
  localparam logic [5:0]  TRIM_MID     = 6'h20;

  // Wake-up hold-off per source, in ns, and as mclk cycles (rounded up)
  localparam longint WAKE_RC_NS  = 50_000;
  localparam longint WAKE_WDT_NS = 100_000;
  localparam longint WAKE_EXT_NS = 25_000;
  localparam logic [11:0] WAKE_RC_CYC  = 12'((WAKE_RC_NS * MCLK_HZ + 999_999_999) / 1_000_000_000);
  localparam logic [11:0] WAKE_WDT_CYC = 12'((WAKE_WDT_NS * MCLK_HZ + 999_999_999) / 1_000_000_000);
  localparam logic [11:0] WAKE_EXT_CYC = 12'((WAKE_EXT_NS * MCLK_HZ + 999_999_999) / 1_000_000_000);

  typedef enum logic [1:0] {SRC_RC, SRC_WDT, SRC_EXT} cgen_src_t;
  typedef enum {ST_HOLD, ST_RUN} cgen_state_t;

  // Special function register access
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } cgen_sfr_req_t;

  // Clock outputs towards the core and peripherals
  typedef struct packed {
    logic cpu_tick;
    logic periph_tick;
    logic machine_cycle;
  } cgen_clk_t;

endpackage

// ===== core/cgen_clock_gen.sv
`timescale 1ns/1ps
// How it works
// - A machine cycle strobe fires once every two CPU clock periods.
// - Selected source forms the oscillator clock feeding the divider; output is CPU clock.
// - Peripheral clock runs at half the CPU clock rate.
// - Doubler configuration bit doubles the RC oscillator rate.
// - Clock source comes from the flash user configuration byte.
// - Six-bit tuning field for the RC oscillator, loaded with a factory value.
// - Only power-on reset reloads the tuning register.
// - Software writes to the tuning register retune the RC oscillator.
// - Tuning register bit 7 switches the clock to the RC oscillator.
// - Low-power bit clears on the general reset (reset_n), not on power-on reset alone; software sets it at slow clocks.
// - Watchdog oscillator at 400 kHz can clock the system.
// - External pin clock from 0 to 18 MHz; otherwise pin is a port input.
// - Wake-up timer holds the CPU clock off, length set by source on wake, fixed at the watchdog length after reset.
// - Divider register divides the oscillator clock, ratio up to 510.
// - Divider may change any time without stalling execution.
module cgen_clock_gen #(
  parameter logic [7:0] FACTORY_TRIM = 8'h20
) (
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  input  wire logic                  power_on_reset_n,
  input  wire logic                  wake_req,
  input  wire logic [7:0]            user_config_byte_one,
  input  wire logic                  external_clock_pin,
  input  wire cgen_pkg::cgen_sfr_req_t sfr_req,
  output logic [7:0]                 sfr_rdata,
  output cgen_pkg::cgen_clk_t        clk_out,
  output logic                       oscillator_clock,
  output logic                       low_power_clock_bit,
  output logic                       port_pin_in,
  output logic                       cpu_clock_running
);

  logic [7:0]               trim_q, trim_d;
  logic [7:0]               dval_q, dval_d;
  logic [7:0]               dval_act_q, dval_act_d;
  logic [7:0]               aux_q, aux_d;
  logic [7:0]               rdata_q, rdata_d;
  logic [cgen_pkg::ACC_W-1:0] acc_q, acc_d;
  logic                     rc_tick_q, rc_tick_d;
  logic [6:0]               wdt_cnt_q, wdt_cnt_d;
  logic                     wdt_tick_q, wdt_tick_d;
  logic                     pin_q, pin_d;
  logic                     ext_tick_q, ext_tick_d;
  logic                     port_q, port_d;
  cgen_pkg::cgen_src_t      src_q, src_d;
  cgen_pkg::cgen_state_t    st_q, st_d;
  logic [11:0]              wake_q, wake_d;
  logic [7:0]               div_cnt_q, div_cnt_d;
  logic                     half_q, half_d;
  logic                     osc_q, osc_d;
  logic                     cpu_q, cpu_d;
  logic                     per_q, per_d;
  logic                     mc_q, mc_d;
  logic                     phase_q, phase_d;
  logic                     run_q, run_d;

  // Map the configuration source field onto the internal source type
  function automatic cgen_pkg::cgen_src_t cfg_src(input logic [7:0] ucfg, input logic rcsel);
    logic [1:0] code;
    code = ucfg[cgen_pkg::UCFG_SRC_LSB +: 2];
    if (rcsel || code == cgen_pkg::UCFG_SRC_RC) begin
      cfg_src = cgen_pkg::SRC_RC;
    end else if (code == cgen_pkg::UCFG_SRC_WDT) begin
      cfg_src = cgen_pkg::SRC_WDT;
    end else begin
      cfg_src = cgen_pkg::SRC_EXT;
    end
  endfunction

  // Wake-up hold-off length for a given source
  function automatic logic [11:0] wake_len(input cgen_pkg::cgen_src_t s);
    unique case (s)
      cgen_pkg::SRC_RC:  wake_len = cgen_pkg::WAKE_RC_CYC;
      cgen_pkg::SRC_WDT: wake_len = cgen_pkg::WAKE_WDT_CYC;
      cgen_pkg::SRC_EXT: wake_len = cgen_pkg::WAKE_EXT_CYC;
    endcase
  endfunction

  // Tuning register: only power-on reset restores the factory value
  always_comb begin
    trim_d = trim_q;
    if (sfr_req.wr && sfr_req.addr == cgen_pkg::SFR_TRIM) begin
      trim_d = sfr_req.wdata;
    end
  end

  always_ff @(posedge mclk or negedge power_on_reset_n) begin
    if (!power_on_reset_n) begin
      trim_q <= FACTORY_TRIM;
    end else begin
      trim_q <= trim_d;
    end
  end

  // Divider and auxiliary registers plus read data
  always_comb begin
    dval_d  = dval_q;
    aux_d   = aux_q;
    rdata_d = rdata_q;
    if (sfr_req.wr && sfr_req.addr == cgen_pkg::SFR_CDIV) begin
      dval_d = sfr_req.wdata;
    end
    if (sfr_req.wr && sfr_req.addr == cgen_pkg::SFR_AUXCT) begin
      aux_d = sfr_req.wdata;
    end
    if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        cgen_pkg::SFR_TRIM:  rdata_d = trim_q;
        cgen_pkg::SFR_CDIV:  rdata_d = dval_q;
        cgen_pkg::SFR_AUXCT: rdata_d = aux_q;
        default:             rdata_d = 8'h00;
      endcase
    end
  end

  // RC oscillator, watchdog oscillator and external pin tick sources
  always_comb begin
    logic [cgen_pkg::ACC_W-1:0] step;
    logic [cgen_pkg::ACC_W:0]   sum;
    sum = '0;
    // Step tracks trim around mid code; a wrapped step is a software hazard
    step = cgen_pkg::ACC_W'(cgen_pkg::RC_STEP
         + cgen_pkg::ACC_W'(trim_q[cgen_pkg::TRIM_W-1:0]) * cgen_pkg::RC_TRIM_LSB
         - cgen_pkg::ACC_W'(cgen_pkg::TRIM_MID) * cgen_pkg::RC_TRIM_LSB);
    if (user_config_byte_one[cgen_pkg::UCFG_DBL_BIT]) begin
      step = {step[cgen_pkg::ACC_W-2:0], 1'b0};
    end
    sum       = {1'b0, acc_q} + {1'b0, step};
    acc_d     = sum[cgen_pkg::ACC_W-1:0];
    rc_tick_d = sum[cgen_pkg::ACC_W];
    // Watchdog oscillator at its nominal rate
    if (wdt_cnt_q == 7'(cgen_pkg::WDT_DIV - 1)) begin
      wdt_cnt_d  = 7'h00;
      wdt_tick_d = 1'b1;
    end else begin
      wdt_cnt_d  = wdt_cnt_q + 7'h01;
      wdt_tick_d = 1'b0;
    end
    // 18 MHz stays under half of mclk, so one edge detector suffices
    pin_d      = external_clock_pin;
    ext_tick_d = external_clock_pin && !pin_q;
    port_d     = (src_q == cgen_pkg::SRC_EXT) ? 1'b0 : external_clock_pin;
  end

  // Source switch, wake-up hold-off and divider
  always_comb begin
    logic osc_tick;
    logic cpu_tick;
    cgen_pkg::cgen_src_t want;
    osc_tick = 1'b0;
    cpu_tick = 1'b0;
    want = cfg_src(user_config_byte_one, trim_q[cgen_pkg::TRIM_SEL_BIT]);
    unique case (src_q)
      cgen_pkg::SRC_RC:  osc_tick = rc_tick_q;
      cgen_pkg::SRC_WDT: osc_tick = wdt_tick_q;
      cgen_pkg::SRC_EXT: osc_tick = ext_tick_q;
    endcase
    src_d      = src_q;
    st_d       = st_q;
    wake_d     = wake_q;
    dval_act_d = dval_act_q;
    div_cnt_d  = div_cnt_q;
    half_d     = half_q;
    osc_d      = osc_tick;
    unique case (st_q)
      cgen_pkg::ST_HOLD: begin
        // Clock gated until the chosen source has settled
        src_d = want;
        if (wake_q == 12'h000) begin
          st_d = cgen_pkg::ST_RUN;
        end else begin
          wake_d = wake_q - 12'h001;
        end
      end
      cgen_pkg::ST_RUN: begin
        if (wake_req) begin
          st_d   = cgen_pkg::ST_HOLD;
          wake_d = wake_len(want);
        end else if (osc_tick) begin
          if (dval_act_q == 8'h00) begin
            cpu_tick = 1'b1;
          end else if (div_cnt_q == dval_act_q - 8'h01) begin
            div_cnt_d = 8'h00;
            half_d    = !half_q;
            cpu_tick  = half_q;
          end else begin
            div_cnt_d = div_cnt_q + 8'h01;
          end
        end
      end
    endcase
    // New divider and source only at a completed CPU period or during the hold-off
    if (cpu_tick || st_q == cgen_pkg::ST_HOLD) begin
      dval_act_d = dval_q;
      div_cnt_d  = 8'h00;
      half_d     = 1'b0;
      if (src_q != want) begin
        src_d = want;
      end
    end
    cpu_d   = cpu_tick;
    phase_d = cpu_tick ? !phase_q : phase_q;
    per_d   = cpu_tick && phase_q;
    mc_d    = cpu_tick && phase_q;
    // Running flag registered from the next state so it lines up with it
    run_d   = (st_d == cgen_pkg::ST_RUN);
  end

  // Registers on the general reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dval_q     <= cgen_pkg::CDIV_RST;
      dval_act_q <= cgen_pkg::CDIV_RST;
      aux_q      <= cgen_pkg::AUXCT_RST;
      rdata_q    <= 8'h00;
      acc_q      <= '0;
      rc_tick_q  <= 1'b0;
      wdt_cnt_q  <= 7'h00;
      wdt_tick_q <= 1'b0;
      pin_q      <= 1'b0;
      ext_tick_q <= 1'b0;
      port_q     <= 1'b0;
      src_q      <= cgen_pkg::SRC_RC;
      st_q       <= cgen_pkg::ST_HOLD;
      wake_q     <= cgen_pkg::WAKE_WDT_CYC;
      div_cnt_q  <= 8'h00;
      half_q     <= 1'b0;
      osc_q      <= 1'b0;
      cpu_q      <= 1'b0;
      per_q      <= 1'b0;
      mc_q       <= 1'b0;
      phase_q    <= 1'b0;
      run_q      <= 1'b0;
    end else begin
      dval_q     <= dval_d;
      dval_act_q <= dval_act_d;
      aux_q      <= aux_d;
      rdata_q    <= rdata_d;
      acc_q      <= acc_d;
      rc_tick_q  <= rc_tick_d;
      wdt_cnt_q  <= wdt_cnt_d;
      wdt_tick_q <= wdt_tick_d;
      pin_q      <= pin_d;
      ext_tick_q <= ext_tick_d;
      port_q     <= port_d;
      src_q      <= src_d;
      st_q       <= st_d;
      wake_q     <= wake_d;
      div_cnt_q  <= div_cnt_d;
      half_q     <= half_d;
      osc_q      <= osc_d;
      cpu_q      <= cpu_d;
      per_q      <= per_d;
      mc_q       <= mc_d;
      phase_q    <= phase_d;
      run_q      <= run_d;
    end
  end

  // Outputs straight from flip-flops
  assign sfr_rdata             = rdata_q;
  assign clk_out.cpu_tick      = cpu_q;
  assign clk_out.periph_tick   = per_q;
  assign clk_out.machine_cycle = mc_q;
  assign oscillator_clock      = osc_q;
  assign low_power_clock_bit   = aux_q[cgen_pkg::AUX_LP_BIT];
  assign port_pin_in           = port_q;
  assign cpu_clock_running     = run_q;

endmodule

// ===== tb/cgen_ext_clk_src.sv
`timescale 1ns/1ps
// Far-side source on the shared clock and port pin
module cgen_ext_clk_src #(
  parameter int HALF_CYC = 3
) (
  input  wire logic mclk,
  input  wire logic run,
  input  wire logic idle_lvl,
  output logic      pin
);
  int cnt;
  initial begin
    pin = 1'b0;
    cnt = 0;
  end
  // Toggles only within a run, on mclk so it never races sampling
  // Kept under 12 MHz, so the reset pin need not be enabled
  always @(posedge mclk) begin
    if (!run) begin
      pin <= idle_lvl;
      cnt <= 0;
    end else if (cnt == HALF_CYC - 1) begin
      pin <= ~pin;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ===== tb/cgen_clock_gen_sva.sv
`timescale 1ns/1ps
module cgen_clock_gen_sva (
  input wire logic                    mclk,
  input wire logic                    reset_n,
  input wire logic                    wake_req,
  input wire logic [7:0]              user_config_byte_one,
  input wire logic                    external_clock_pin,
  input wire cgen_pkg::cgen_sfr_req_t sfr_req,
  input wire logic [7:0]              sfr_rdata,
  input wire cgen_pkg::cgen_clk_t     clk_out,
  input wire logic                    low_power_clock_bit,
  input wire logic                    port_pin_in,
  input wire logic                    cpu_clock_running
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic known_q;
  logic half_q;
  // Phase of the peripheral tick, learnt from the first one seen
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      known_q <= 1'b0;
      half_q  <= 1'b0;
    end else if (clk_out.cpu_tick) begin
      known_q <= known_q | clk_out.periph_tick;
      half_q  <= ~clk_out.periph_tick;
    end
  end
  sequence s_wake;
    wake_req && cpu_clock_running;
  endsequence
  sequence s_trim_wr_rd;
    sfr_req.wr && sfr_req.addr == cgen_pkg::SFR_TRIM
    ##2 sfr_req.rd && sfr_req.addr == cgen_pkg::SFR_TRIM;
  endsequence
  property p_hold_quiet;
    !cpu_clock_running && !$past(cpu_clock_running) |-> !clk_out.cpu_tick;
  endproperty
  property p_periph_in_cpu;
    clk_out.periph_tick |-> clk_out.cpu_tick;
  endproperty
  property p_machine;
    clk_out.machine_cycle == clk_out.periph_tick;
  endproperty
  property p_alternate;
    clk_out.cpu_tick && known_q |-> clk_out.periph_tick == half_q;
  endproperty
  property p_lp_reset;
    $rose(reset_n) |-> !low_power_clock_bit;
  endproperty
  property p_lp_write;
    sfr_req.wr && sfr_req.addr == cgen_pkg::SFR_AUXCT
    |=> low_power_clock_bit == $past(sfr_req.wdata[7]);
  endproperty
  property p_wake;
    s_wake |=> !cpu_clock_running [*8];
  endproperty
  property p_port;
    user_config_byte_one[1] |=> port_pin_in == $past(external_clock_pin);
  endproperty
  property p_trim_rw;
    s_trim_wr_rd |=> sfr_rdata == $past(sfr_req.wdata, 3);
  endproperty
  a_hold_quiet: assert property (p_hold_quiet) else $error("cpu tick while held");
  a_periph_in_cpu: assert property (p_periph_in_cpu) else $error("lone periph tick");
  a_machine: assert property (p_machine) else $error("machine cycle off");
  a_alternate: assert property (p_alternate) else $error("periph phase off");
  a_lp_reset: assert property (p_lp_reset) else $error("low power set at reset");
  a_lp_write: assert property (p_lp_write) else $error("low power not written");
  a_wake: assert property (p_wake) else $error("wake hold too short");
  a_port: assert property (p_port) else $error("port pin not passed");
  a_trim_rw: assert property (p_trim_rw) else $error("trim readback wrong");
endmodule
bind cgen_clock_gen cgen_clock_gen_sva u_sva (.mclk, .reset_n, .wake_req,
  .user_config_byte_one, .external_clock_pin, .sfr_req, .sfr_rdata, .clk_out,
  .low_power_clock_bit, .port_pin_in, .cpu_clock_running);

// ===== tb/cgen_clock_gen_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin bad_count++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module cgen_clock_gen_tb;
  localparam logic [7:0] FTRIM = 8'h25;
  logic mclk, reset_n, power_on_reset_n, wake_req, ext_run, idle_lvl, external_clock_pin;
  logic [7:0] user_config_byte_one, sfr_rdata, d;
  logic oscillator_clock, low_power_clock_bit, port_pin_in, cpu_clock_running;
  cgen_pkg::cgen_sfr_req_t sfr_req;
  cgen_pkg::cgen_clk_t     clk_out;
  int bad_count, tests_run, n;
  cgen_clock_gen #(.FACTORY_TRIM(FTRIM)) dut (.mclk, .reset_n, .power_on_reset_n, .wake_req,
    .user_config_byte_one, .external_clock_pin, .sfr_req, .sfr_rdata, .clk_out,
    .oscillator_clock, .low_power_clock_bit, .port_pin_in, .cpu_clock_running);
  cgen_ext_clk_src #(.HALF_CYC(3)) u_src (.mclk, .run(ext_run), .idle_lvl,
    .pin(external_clock_pin));
  // 40 MHz master clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  function automatic logic near(int a, int b, int t);
    return (a >= b - t) && (a <= b + t);
  endfunction
  // RC ticks in a 4096-cycle window: accumulator step over 256
  function automatic int exp_rc(logic [5:0] t, int dbl);
    return ((int'(cgen_pkg::RC_STEP) + (int'(t) - 32) * int'(cgen_pkg::RC_TRIM_LSB)) << dbl) >> 8;
  endfunction
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    sfr_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
    @(posedge mclk);
    sfr_req.wr <= 1'b0;
    #1;
  endtask
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    sfr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: sfr_req.wdata};
    @(posedge mclk);
    sfr_req.rd <= 1'b0;
    #1 v = sfr_rdata;
  endtask
  // Config only moves while reset is held, as flash would
  task automatic do_reset(input logic por, input logic [7:0] cfg);
    @(posedge mclk);
    reset_n <= 1'b0;
    power_on_reset_n <= !por;
    user_config_byte_one <= cfg;
    repeat (5) @(posedge mclk); // Five edges seen in reset
    reset_n <= 1'b1;
    power_on_reset_n <= 1'b1;
  endtask
  task automatic wait_run();
    int i;
    i = 0;
    while (cpu_clock_running !== 1'b1 && i < 6000) begin
      @(posedge mclk);
      #1 i++;
    end
    `CHK("running", 1'b1, cpu_clock_running)
  endtask
  task automatic count_osc(output int c);
    c = 0;
    repeat (4096) begin
      @(posedge mclk);
      #1 c += oscillator_clock;
    end
  endtask
  // Oscillator ticks within one cpu clock period
  task automatic period(output int c);
    int i;
    repeat (3) begin
      i = 0;
      do begin @(posedge mclk); #1 i++; end while (clk_out.cpu_tick !== 1'b1 && i < 4000);
    end
    c = 0;
    i = 0;
    do begin
      @(posedge mclk);
      #1 c += oscillator_clock;
      i++;
    end while (clk_out.cpu_tick !== 1'b1 && i < 4000);
  endtask
  task automatic wake(output int c);
    @(posedge mclk);
    wake_req <= 1'b1;
    @(posedge mclk);
    wake_req <= 1'b0;
    c = 0;
    do begin @(posedge mclk); #1 c++; end while (cpu_clock_running !== 1'b1 && c < 6000);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard, nearly twice the roughly 48k cycles the tests take
  initial begin
    #(25 * 90000);
    bad_count++;
    report_and_stop();
  end
  initial begin
    reset_n = 1'b0;
    power_on_reset_n = 1'b0;
    wake_req = 1'b0;
    ext_run = 1'b0;
    idle_lvl = 1'b0;
    user_config_byte_one = 8'h03;
    sfr_req = '0;
    do_reset(1'b1, 8'h03);
    sfr_rd(cgen_pkg::SFR_TRIM, d); `CHK("trim", FTRIM, d)
    sfr_rd(cgen_pkg::SFR_AUXCT, d); `CHK("aux", cgen_pkg::AUXCT_RST, d)
    sfr_rd(cgen_pkg::SFR_CDIV, d); `CHK("divider", cgen_pkg::CDIV_RST, d)
    sfr_rd(8'h00, d); `CHK("unmapped", 8'h00, d)
    sfr_wr(cgen_pkg::SFR_AUXCT, 8'h80); `CHK("lowpow", 1'b1, low_power_clock_bit)
    sfr_wr(cgen_pkg::SFR_TRIM, 8'h1A);
    sfr_rd(cgen_pkg::SFR_TRIM, d); `CHK("trim wr", 8'h1A, d)
    do_reset(1'b0, 8'h03);
    sfr_rd(cgen_pkg::SFR_TRIM, d); `CHK("trim warm", 8'h1A, d)
    `CHK("lowpow rst", 1'b0, low_power_clock_bit)
    wait_run();
    count_osc(n); `CHK("rc rate", 1'b1, near(n, exp_rc(6'h1A, 0), 1))
    for (int i = 0; i < 4; i++) begin
      sfr_wr(cgen_pkg::SFR_CDIV, i == 3 ? 8'hFF : 8'(i * i));
      period(n); `CHK("div", (i == 0) ? 1 : (i == 3 ? 510 : 2 * i * i), n)
    end
    sfr_wr(cgen_pkg::SFR_CDIV, 8'h00);
    wake(n); `CHK("wake rc", 1'b1, near(n, cgen_pkg::WAKE_RC_CYC, 2))
    do_reset(1'b1, 8'h0B);
    sfr_rd(cgen_pkg::SFR_TRIM, d); `CHK("trim por", FTRIM, d)
    wait_run();
    count_osc(n); `CHK("dbl rate", 1'b1, near(n, exp_rc(FTRIM[5:0], 1), 2))
    idle_lvl <= 1'b1;
    do_reset(1'b0, 8'h02);
    wait_run();
    `CHK("port", 1'b1, port_pin_in)
    count_osc(n); `CHK("wdt rate", 1'b1, near(n, 41, 1))
    sfr_wr(cgen_pkg::SFR_TRIM, 8'hA5);
    // Switch lands at the next slow cpu tick, up to one watchdog period away
    repeat (200) @(posedge mclk);
    count_osc(n); `CHK("rc switch", 1'b1, near(n, exp_rc(FTRIM[5:0], 0), 2))
    sfr_wr(cgen_pkg::SFR_TRIM, FTRIM);
    ext_run <= 1'b1;
    do_reset(1'b0, 8'h00);
    wait_run();
    count_osc(n); `CHK("ext rate", 1'b1, near(n, 683, 2))
    `CHK("port ext", 1'b0, port_pin_in)
    wake(n); `CHK("wake ext", 1'b1, near(n, cgen_pkg::WAKE_EXT_CYC, 2))
    report_and_stop();
  end
endmodule
